// *** core/aao_consts.vh ***
// Shared constants for the add and AND execute slice
`ifndef AAO_CONSTS_VH
`define AAO_CONSTS_VH

// Register byte offsets
`define AAO_OFS_CTRL 8'h00
`define AAO_OFS_INSTR 8'h04
`define AAO_OFS_STAT 8'h08
`define AAO_OFS_FLAGS 8'h0c
`define AAO_OFS_ACC 8'h10
`define AAO_OFS_BANK 8'h14
`define AAO_OFS_INDEX 8'h18
`define AAO_OFS_MADDR 8'h1c
`define AAO_OFS_MDATA 8'h20
`define AAO_OFS_LADDR 8'h24

// Reset values
`define AAO_RST_CTRL 1'b0
`define AAO_RST_ACC 8'h00
`define AAO_RST_FLAGS 5'h00
`define AAO_RST_BANK 4'h0
`define AAO_RST_INDEX 12'h000
`define AAO_RST_MADDR 12'h000
`define AAO_RST_INSTR 16'h0000

// Flag positions in the flags register
`define AAO_FLG_C 0
`define AAO_FLG_DC 1
`define AAO_FLG_Z 2
`define AAO_FLG_OV 3
`define AAO_FLG_N 4

// Status register fields
`define AAO_STAT_BUSY 0
`define AAO_STAT_PH_LO 4
`define AAO_STAT_PH_HI 5
`define AAO_STAT_IDX 8

// Control register fields
`define AAO_CTRL_EXT 0

// Instruction word fields and opcodes
`define AAO_OPC_HI 15
`define AAO_OPC_LO 8
`define AAO_OPF_LO 10
`define AAO_BIT_DEST 9
`define AAO_BIT_BMODE 8
`define AAO_OPC_ADD_LIT 8'h0f
`define AAO_OPC_AND_LIT 8'h0b
`define AAO_OPF_ADD_FILE 6'h09
`define AAO_OPF_ADDC_FILE 6'h08

// Access bank split and indexed window limit
`define AAO_IDX_LIMIT 8'h5f
`define AAO_ACC_HI_BANK 4'hf

// Bus responses
`define AAO_RESP_OKAY 2'b00
`define AAO_RESP_SLVERR 2'b10

`endif

// *** core/aao_adder8.v ***
// Eight-bit adder with carry in and arithmetic flag outputs
module aao_adder8 (
  // Operands
  input wire [7:0] a_i,
  input wire [7:0] b_i,
  input wire cin_i,
  // Result and flags
  output wire [7:0] sum_o,
  output wire c_o,
  output wire dc_o,
  output wire ov_o,
  output wire n_o,
  output wire z_o
);

  wire [4:0] lo_sum;
  wire [8:0] full_sum;

  // Low nibble carried separately for the digit carry
  assign lo_sum = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
  assign full_sum = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
  assign sum_o = full_sum[7:0];
  assign c_o = full_sum[8];
  assign dc_o = lo_sum[4];
  // Signed overflow: like signs in, other sign out
  assign ov_o = (a_i[7] == b_i[7]) && (full_sum[7] != a_i[7]);
  assign n_o = full_sum[7];
  assign z_o = (full_sum[7:0] == 8'h00);

endmodule // aao_adder8

// *** core/aao_addr_gen.v ***
// File operand address generation for banked and indexed modes
`include "aao_consts.vh"

module aao_addr_gen (
  // Instruction fields
  input wire [7:0] f_i,
  input wire bmode_i,
  // Addressing state
  input wire [3:0] bank_i,
  input wire ext_en_i,
  input wire [11:0] index_i,
  // Effective address
  output reg [11:0] addr_o,
  output reg indexed_o
);

  // Pick indexed, access bank or pointer-selected bank
  always @*
  begin
    indexed_o = 1'b0;
    if (bmode_i)
      addr_o = {bank_i, f_i};
    else if (ext_en_i && (f_i <= `AAO_IDX_LIMIT))
    begin
      // Wraps within the data space; no bound check on the base
      addr_o = index_i + {4'h0, f_i};
      indexed_o = 1'b1;
    end
    else if (f_i <= `AAO_IDX_LIMIT)
      addr_o = {4'h0, f_i};
    else
      addr_o = {`AAO_ACC_HI_BANK, f_i};
  end

endmodule // aao_addr_gen

// *** core/aao_core.v ***
// Execute slice for add and AND instructions with an AXI4-Lite register port
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`include "aao_consts.vh"

// Contract
// - Add literal opcode adds literal into accumulator
// - Plain file add routes result by destination bit
// - File add with carry, routed by destination
// - All adds update N, OV, C, DC, Z
// - Bank-mode 0 access bank, 1 pointer bank
// - Indexed offset when extended, mode 0, f<=95
// - AND literal into accumulator, only N, Z change
// - One word, four phases: decode, read, process, write
// - File address is instruction low byte
module aao_core (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Write address channel
  input wire [7:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  // Write data channel
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  // Write response channel
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  // Read address channel
  input wire [7:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  // Read data channel
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // Execution state
  output reg busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Phase codes and storage

  localparam PH_Q1 = 2'b00;
  localparam PH_Q2 = 2'b01;
  localparam PH_Q3 = 2'b10;
  localparam PH_Q4 = 2'b11;

  // Opcode classes held from decode
  localparam OP_NONE = 3'd0;
  localparam OP_ADD_LIT = 3'd1;
  localparam OP_AND_LIT = 3'd2;
  localparam OP_ADD_FILE = 3'd3;
  localparam OP_ADDC_FILE = 3'd4;

  reg [7:0] data_mem [0:4095];

  reg ext_en_r;
  reg [15:0] instr_r;
  reg [7:0] acc_r;
  reg [4:0] flags_r;
  reg [3:0] bank_r;
  reg [11:0] index_r;
  reg [11:0] maddr_r;
  reg [11:0] ea_r;
  reg idx_used_r;
  reg [1:0] phase_r;
  reg [2:0] op_r;
  reg [2:0] op_nxt;
  reg [7:0] opnd_r;
  reg cin_r;
  reg [7:0] res_r;
  reg [4:0] flags_res_r;

  reg aw_got_r;
  reg w_got_r;
  reg [7:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and datapath helpers

  wire [11:0] ea_nxt;
  wire idx_nxt;
  wire [7:0] add_sum;
  wire add_c;
  wire add_dc;
  wire add_ov;
  wire add_n;
  wire add_z;
  wire [7:0] and_res;
  wire is_file_op;
  wire dest_file;

  // Opcode classification from the held instruction word
  always @*
  begin
    op_nxt = OP_NONE;
    if (instr_r[`AAO_OPC_HI:`AAO_OPC_LO] == `AAO_OPC_ADD_LIT)
      op_nxt = OP_ADD_LIT;
    else if (instr_r[`AAO_OPC_HI:`AAO_OPC_LO] == `AAO_OPC_AND_LIT)
      op_nxt = OP_AND_LIT;
    else if (instr_r[`AAO_OPC_HI:`AAO_OPF_LO] == `AAO_OPF_ADD_FILE)
      op_nxt = OP_ADD_FILE;
    else if (instr_r[`AAO_OPC_HI:`AAO_OPF_LO] == `AAO_OPF_ADDC_FILE)
      op_nxt = OP_ADDC_FILE;
  end

  assign is_file_op = (op_r == OP_ADD_FILE) || (op_r == OP_ADDC_FILE);
  assign dest_file = instr_r[`AAO_BIT_DEST];

  // Low byte is the file address within the chosen bank
  aao_addr_gen u_addr (
    .f_i(instr_r[7:0]),
    .bmode_i(instr_r[`AAO_BIT_BMODE]),
    .bank_i(bank_r),
    .ext_en_i(ext_en_r),
    .index_i(index_r),
    .addr_o(ea_nxt),
    .indexed_o(idx_nxt)
  );

  // Carry only enters for the carry variant, from the sampled copy
  aao_adder8 u_add (
    .a_i(acc_r),
    .b_i(opnd_r),
    .cin_i(cin_r),
    .sum_o(add_sum),
    .c_o(add_c),
    .dc_o(add_dc),
    .ov_o(add_ov),
    .n_o(add_n),
    .z_o(add_z)
  );

  assign and_res = acc_r & opnd_r;

  ////////////////////////////////////////////////////////////////////////////
  // Bus write decode

  wire do_wr;
  wire [7:0] wr_word;
  wire wr_ok;

  assign do_wr = aw_got_r && w_got_r && !s_axi_bvalid_o;
  assign wr_word = {awaddr_r[7:2], 2'b00};
  assign wr_ok = (wr_word <= `AAO_OFS_LADDR);

  // Byte-lane merge for the low sixteen bits
  function [15:0] lane_merge;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0] strb;
    begin
      lane_merge = {strb[1] ? new_v[15:8] : old_v[15:8],
                    strb[0] ? new_v[7:0] : old_v[7:0]};
    end
  endfunction

  wire [15:0] instr_wr;
  wire [15:0] index_wr;
  wire [15:0] maddr_wr;

  assign instr_wr = lane_merge(instr_r, wdata_r[15:0], wstrb_r[1:0]);
  assign index_wr = lane_merge({4'h0, index_r}, wdata_r[15:0], wstrb_r[1:0]);
  assign maddr_wr = lane_merge({4'h0, maddr_r}, wdata_r[15:0], wstrb_r[1:0]);

  // Software writes while an instruction runs are dropped
  wire sw_wr;
  assign sw_wr = do_wr && !busy_o;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and architectural state

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ext_en_r <= `AAO_RST_CTRL;
      instr_r <= `AAO_RST_INSTR;
      acc_r <= `AAO_RST_ACC;
      flags_r <= `AAO_RST_FLAGS;
      bank_r <= `AAO_RST_BANK;
      index_r <= `AAO_RST_INDEX;
      maddr_r <= `AAO_RST_MADDR;
      ea_r <= 12'h000;
      idx_used_r <= 1'b0;
      phase_r <= PH_Q1;
      op_r <= OP_NONE;
      opnd_r <= 8'h00;
      cin_r <= 1'b0;
      res_r <= 8'h00;
      flags_res_r <= 5'h00;
      busy_o <= 1'b0;
    end
    else if (busy_o)
    begin
      // One instruction cycle is four clocks
      case (phase_r)
        PH_Q1:
        begin
          op_r <= op_nxt;
          phase_r <= PH_Q2;
        end
        PH_Q2:
        begin
          // Operand fetch; carry is frozen here, before any update
          if (is_file_op)
          begin
            opnd_r <= data_mem[ea_nxt];
            ea_r <= ea_nxt;
            idx_used_r <= idx_nxt;
          end
          else
            opnd_r <= instr_r[7:0];
          cin_r <= (op_r == OP_ADDC_FILE) && flags_r[`AAO_FLG_C];
          phase_r <= PH_Q3;
        end
        PH_Q3:
        begin
          // Process data into a staged result and flag set
          flags_res_r <= flags_r;
          if (op_r == OP_AND_LIT)
          begin
            res_r <= and_res;
            flags_res_r[`AAO_FLG_N] <= and_res[7];
            flags_res_r[`AAO_FLG_Z] <= (and_res == 8'h00);
          end
          else if (op_r != OP_NONE)
          begin
            res_r <= add_sum;
            flags_res_r <= {add_n, add_ov, add_z, add_dc, add_c};
          end
          phase_r <= PH_Q4;
        end
        PH_Q4:
        begin
          // Write destination and flags, then go idle
          if (op_r != OP_NONE)
          begin
            flags_r <= flags_res_r;
            if (!(is_file_op && dest_file))
              acc_r <= res_r;
          end
          phase_r <= PH_Q1;
          busy_o <= 1'b0;
        end
        default:
        begin
          phase_r <= PH_Q1;
          busy_o <= 1'b0;
        end
      endcase
    end
    else if (sw_wr)
    begin
      case (wr_word)
        `AAO_OFS_CTRL:
          if (wstrb_r[0])
            ext_en_r <= wdata_r[`AAO_CTRL_EXT];
        `AAO_OFS_INSTR:
        begin
          // Any write here launches the held word
          instr_r <= instr_wr;
          phase_r <= PH_Q1;
          busy_o <= 1'b1;
        end
        `AAO_OFS_FLAGS:
          if (wstrb_r[0])
            flags_r <= wdata_r[4:0];
        `AAO_OFS_ACC:
          if (wstrb_r[0])
            acc_r <= wdata_r[7:0];
        `AAO_OFS_BANK:
          if (wstrb_r[0])
            bank_r <= wdata_r[3:0];
        `AAO_OFS_INDEX:
          index_r <= index_wr[11:0];
        `AAO_OFS_MADDR:
          maddr_r <= maddr_wr[11:0];
        default:
          index_r <= index_r;
      endcase
    end
  end

  // Data memory; the core write wins because bus writes are dropped while busy
  always @(posedge clk_i)
  begin
    if (busy_o && (phase_r == PH_Q4) && is_file_op && dest_file)
      data_mem[ea_r] <= res_r;
    else if (sw_wr && (wr_word == `AAO_OFS_MDATA) && wstrb_r[0])
      data_mem[maddr_r] <= wdata_r[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  reg [31:0] rd_mux;
  reg rd_hit;
  wire [7:0] rd_word;

  assign rd_word = {s_axi_araddr_i[7:2], 2'b00};

  // Read data select; unmapped words return zero with an error
  always @*
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (rd_word)
      `AAO_OFS_CTRL: rd_mux = {31'h0, ext_en_r};
      `AAO_OFS_INSTR: rd_mux = {16'h0000, instr_r};
      `AAO_OFS_STAT: rd_mux = {23'h0, idx_used_r, 2'b00, phase_r, 3'b000, busy_o};
      `AAO_OFS_FLAGS: rd_mux = {27'h0, flags_r};
      `AAO_OFS_ACC: rd_mux = {24'h0, acc_r};
      `AAO_OFS_BANK: rd_mux = {28'h0, bank_r};
      `AAO_OFS_INDEX: rd_mux = {20'h0, index_r};
      `AAO_OFS_MADDR: rd_mux = {20'h0, maddr_r};
      `AAO_OFS_MDATA: rd_mux = {24'h0, data_mem[maddr_r]};
      `AAO_OFS_LADDR: rd_mux = {20'h0, ea_r};
      default: rd_hit = 1'b0;
    endcase
  end

  // Address and data are taken separately, answered once both are in
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `AAO_RESP_OKAY;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata_i;
        wstrb_r <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (do_wr)
      begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_ok ? `AAO_RESP_OKAY : `AAO_RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i)
      begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // Single outstanding read, data registered at the address handshake
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `AAO_RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_mux;
      s_axi_rresp_o <= rd_hit ? `AAO_RESP_OKAY : `AAO_RESP_SLVERR;
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

endmodule // aao_core

// *** tb/aao_core_props.sv ***
// Assertion checker for the add and AND execute slice
module aao_core_props (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Write channels
  input wire [7:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  input wire s_axi_awready_o,
  input wire s_axi_wvalid_i,
  input wire s_axi_wready_o,
  input wire [1:0] s_axi_bresp_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  // Read channels
  input wire [7:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire [31:0] s_axi_rdata_o,
  input wire [1:0] s_axi_rresp_o,
  input wire s_axi_rvalid_o,
  // Execution
  input wire busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  //////////////////////////////////////////////////////////////////////////
  // Last accepted addresses, since a response alone does not name its word
  reg [7:0] wa_r;
  reg [7:0] ra_r;
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wa_r <= 8'h00;
      ra_r <= 8'h00;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
        wa_r <= s_axi_awaddr_i;
      if (s_axi_arvalid_i && s_axi_arready_o)
        ra_r <= s_axi_araddr_i;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Steps of a write and of an instruction launch
  sequence s_wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_instr_done;
    $rose(s_axi_bvalid_o) && wa_r[7:2] == 6'h01;
  endsequence
  // Bus timing and response codes
  chk_wr_answer: assert property (s_wr_taken |-> ##1 !s_axi_bvalid_o ##1 s_axi_bvalid_o)
    else $error("write answer late or early");
  chk_wr_code: assert property ($rose(s_axi_bvalid_o) |->
    s_axi_bresp_o == ((wa_r[7:2] > 6'h09) ? 2'b10 : 2'b00))
    else $error("write response code wrong");
  chk_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
    s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read answer not next cycle");
  chk_rd_unmapped: assert property ($rose(s_axi_rvalid_o) && ra_r[7:2] > 6'h09 |->
    s_axi_rresp_o == 2'b10 && s_axi_rdata_o == 32'h0)
    else $error("unmapped read not refused");
  chk_ready_back: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
    !s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o)
    else $error("write channels not reopened");
  // Instruction cycle of four phases
  chk_busy_start: assert property (s_instr_done ##0 !$past(busy_o) |-> busy_o)
    else $error("instruction write did not start");
  chk_busy_cause: assert property ($rose(busy_o) |-> s_instr_done)
    else $error("busy without instruction write");
  chk_busy_len: assert property ($rose(busy_o) |-> busy_o [*4] ##1 !busy_o)
    else $error("instruction not four cycles");
endmodule // aao_core_props

bind aao_core aao_core_props aao_core_props_i (
  .clk_i, .srst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
  .s_axi_rresp_o, .s_axi_rvalid_o, .busy_o
);

// *** tb/tb_top.sv ***
// Self-checking bench for the add and AND execute slice
`include "aao_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] rsp_ok = `AAO_RESP_OKAY;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
  logic [31:0] w_d = 32'h0;
  logic [3:0] w_s = 4'hf;
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  wire aw_rdy, w_rdy, b_v, ar_rdy, r_v, busy;
  wire [1:0] b_resp, r_resp;
  wire [31:0] r_d;
  logic [33:0] exq[$];
  logic [33:0] got, want;
  int err_total = 0;
  int comparisons = 0;
  int seed = 49;
  //////////////////////////////////////////////////////////////////////////
  // Clock, 20 ns period
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  aao_core aao_core_i (
    .clk_i(clk_i), .srst_i(srst_i),
    .s_axi_awaddr_i(aw_a), .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_rdy),
    .s_axi_wdata_i(w_d), .s_axi_wstrb_i(w_s), .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_rdy),
    .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r),
    .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_rdy),
    .s_axi_rdata_o(r_d), .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_v),
    .s_axi_rready_i(r_r), .busy_o(busy)
  );
  //////////////////////////////////////////////////////////////////////////
  // Scoreboard: every answer meets the oldest noted expectation
  always @(posedge clk_i)
  begin
    if ((r_v && r_r) || (b_v && b_r))
    begin
      got = r_v ? {r_resp, r_d} : {b_resp, 32'h0};
      want = (exq.size() != 0) ? exq.pop_front() : ~got;
      comparisons++;
      if (got !== want)
      begin
        err_total++;
        $display("[ERR] %0t got %h want %h", $time, got, want);
      end
    end
  end
  // Verdict and end of run
  task automatic results;
  begin
    if (err_total == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  // One clock of a bounded wait; a hang counts as a mismatch
  task automatic tick(inout int n);
  begin
    @(posedge clk_i);
    n++;
    if (n > 50)
    begin
      err_total++;
      results();
    end
  end
  endtask
  // Write with address and data offered together, held until taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
    int n;
  begin
    n = 0;
    exq.push_back({rsp, 32'h0});
    @(posedge clk_i);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do
    begin
      tick(n);
      if (aw_rdy)
        aw_v <= 1'b0;
      if (w_rdy)
        w_v <= 1'b0;
    end
    while (!b_v);
    b_r <= 1'b0;
  end
  endtask
  // Read; the scoreboard compares the returned word
  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
    int n;
  begin
    n = 0;
    exq.push_back({rsp, d});
    @(posedge clk_i);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do
    begin
      tick(n);
      if (ar_rdy)
        ar_v <= 1'b0;
    end
    while (!r_v);
    r_r <= 1'b0;
  end
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Main sequence: reset values, refusals, then random instructions
  initial
  begin
    logic [7:0] lit, a0, m, b, r;
    logic [4:0] fl, fe, h;
    logic [3:0] bk;
    logic [11:0] ix, ea;
    logic [8:0] s;
    logic [15:0] ins;
    logic am, d, ext, idx, c, fd;
    int i, op, n;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    for (i = 0; i < 10; i++)
      if (i != 8)
        axr(8'(i * 4), 32'h0, rsp_ok);
    axr(8'h28, 32'h0, `AAO_RESP_SLVERR);
    axw(8'hfc, 32'h1234, `AAO_RESP_SLVERR);
    // Lane 0 disabled: an 8-bit register must keep its value
    w_s <= 4'he;
    axw(`AAO_OFS_ACC, 32'hff, rsp_ok);
    w_s <= 4'hf;
    axr(`AAO_OFS_ACC, 32'h0, rsp_ok);
    for (i = 0; i < 48; i++)
    begin
      op = i % 5;
      a0 = 8'($random(seed));
      lit = 8'($random(seed));
      m = 8'($random(seed));
      fl = 5'($random(seed));
      bk = 4'($random(seed));
      ix = 12'($random(seed));
      {am, d, ext} = 3'($random(seed));
      // Operand address as software expects it to be formed
      idx = !am && ext && lit <= `AAO_IDX_LIMIT;
      ea = idx ? ix + {4'h0, lit} :
        {am ? bk : (lit > `AAO_IDX_LIMIT ? `AAO_ACC_HI_BANK : 4'h0), lit};
      axw(`AAO_OFS_CTRL, {31'h0, ext}, rsp_ok);
      axw(`AAO_OFS_BANK, {28'h0, bk}, rsp_ok);
      axw(`AAO_OFS_INDEX, {20'h0, ix}, rsp_ok);
      axw(`AAO_OFS_ACC, {24'h0, a0}, rsp_ok);
      axw(`AAO_OFS_FLAGS, {27'h0, fl}, rsp_ok);
      axw(`AAO_OFS_MADDR, {20'h0, ea}, rsp_ok);
      axw(`AAO_OFS_MDATA, {24'h0, m}, rsp_ok);
      case (op)
        0: ins = {`AAO_OPC_ADD_LIT, lit};
        1: ins = {`AAO_OPC_AND_LIT, lit};
        2: ins = {`AAO_OPF_ADD_FILE, d, am, lit};
        3: ins = {`AAO_OPF_ADDC_FILE, d, am, lit};
        // Undecoded opcode: four phases, nothing changes
        default: ins = {8'h00, lit};
      endcase
      // Expected result; carry in is the flag held before the instruction
      b = (op < 2) ? lit : m;
      c = (op == 3) && fl[0];
      s = a0 + b + c;
      h = a0[3:0] + b[3:0] + c;
      r = (op == 1) ? (a0 & b) : (op == 4) ? a0 : s[7:0];
      fe = (op == 4) ? fl : (op == 1) ? {r[7], fl[3], r == 8'h00, fl[1:0]} :
        {r[7], (a0[7] == b[7]) && (r[7] != a0[7]), r == 8'h00, h[4], s[8]};
      fd = (op == 2 || op == 3) && d;
      axw(`AAO_OFS_INSTR, {16'h0, ins}, rsp_ok);
      // Lands while busy, so it must be dropped yet answered
      axw(`AAO_OFS_ACC, {24'h0, ~r}, rsp_ok);
      n = 0;
      while (busy !== 1'b0)
        tick(n);
      axr(`AAO_OFS_ACC, {24'h0, fd ? a0 : r}, rsp_ok);
      axr(`AAO_OFS_FLAGS, {27'h0, fe}, rsp_ok);
      axr(`AAO_OFS_MDATA, {24'h0, fd ? r : m}, rsp_ok);
      if (op == 2 || op == 3)
      begin
        axr(`AAO_OFS_LADDR, {20'h0, ea}, rsp_ok);
        axr(`AAO_OFS_STAT, {23'h0, idx, 8'h00}, rsp_ok);
      end
    end
    results();
  end
endmodule // tb_top
